// ### verilog/rpl_pkg.sv
// Constants, register map and carrier types for the host pin logic.
// Assumes a single 200 MHz clock and APB access with 32-bit data.
package rpl_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_NS = 5;
    localparam int PWM_PERIOD_US = 20;
    localparam int PWM_PERIOD_CYC = PWM_PERIOD_US * 1000 / CLK_NS;
    // Round down so that 256 steps never overrun the period.
    localparam int PWM_STEP_CYC = PWM_PERIOD_CYC / 256;
    localparam logic [3:0] PWM_STEP_LAST = 4'(PWM_STEP_CYC - 1);

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_OUT = 8'h08;
    localparam logic [7:0] OFS_IN = 8'h0C;
    localparam logic [7:0] OFS_PULL = 8'h10;
    localparam logic [7:0] OFS_WAKE = 8'h14;
    localparam logic [7:0] OFS_SLP_DIR = 8'h18;
    localparam logic [7:0] OFS_SLP_LVL = 8'h1C;
    localparam logic [7:0] OFS_PON = 8'h20;
    localparam logic [7:0] OFS_ALT = 8'h24;
    localparam logic [7:0] OFS_PULSE_WIDTH_OUT_0 = 8'h28;
    localparam logic [7:0] OFS_PULSE_WIDTH_OUT_1 = 8'h2C;
    localparam logic [7:0] OFS_STAT = 8'h30;
    localparam logic [7:0] OFS_IRQ_ST = 8'h34;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h38;
    localparam logic [7:0] OFS_IRQ_EN = 8'h3C;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_PROTO = 0;
    localparam int CTRL_BASE = 1;
    localparam int ALT_DE = 0;
    localparam int ALT_SPI = 1;
    localparam int ALT_ANT = 2;
    localparam int IRQ_SOP = 0;
    localparam int IRQ_EOP = 1;
    localparam int IRQ_HOP = 2;
    localparam int IRQ_WAKE = 3;
    localparam int GPIO_N = 6;
    localparam int WAKE_N = 4;
    localparam int IRQ_N = 4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [5:0] GPIO_RST = 6'h00;
    localparam logic [5:0] PON_RST = 6'h00;
    localparam logic [3:0] SLP_RST = 4'h0;
    localparam logic [2:0] ALT_RST = 3'h0;
    localparam logic [7:0] PWM_RST = 8'h00;
    localparam logic [3:0] IRQ_RST = 4'h0;

    // Status word from the radio core.
    typedef struct packed {
        logic sop_done;     // Start-of-packet symbol just ended.
        logic eop_done;     // End-of-packet symbol just ended.
        logic tx_busy;      // Transmitting data.
        logic rx_busy;      // Receiving data.
        logic hop_locked;   // Remote locked to hopping pattern.
        logic remote_up;    // Base has at least one remote.
        logic serial_rx_pending; // Serial receive data pending.
        logic rs485_de;     // Line driver enable request.
        logic ant_sel;      // Antenna diversity selection.
    } rpl_core_t;

endpackage

// ### verilog/rpl_pin_logic.sv
// Host-facing pin logic of the radio module: markers, straps, GPIO, PWM.
// Assumes inputs synchronous to clk_in except the three synchronised pins,
// and an APB master that holds each request until pready.
//
// How it works
// - Frame marker rises when start-of-packet symbol completes, rx or tx.
// - Frame marker falls when end-of-packet symbol completes.
// - Ports 0-3 as inputs offer pull-up and wake from sleep.
// - Ports 0-3 take power-on level and own sleep direction and level.
// - Port 3 may drive the line driver enable instead.
// - Port 4 offers pull-up, power-on level, or serial receive pending flag.
// - Port 5 like port 4, or antenna diversity control output.
// - Two independent PWM outputs with 8-bit duty resolution.
// - Sleep input rising requests sleep; module sleeps until it falls or a port wakes it.
// - Sleep input low after sleep causes a power-on reset of the pin state only.
// - Rising edges on hop align input align hop timing.
// - Strap low selects protocol mode, high selects transparent mode.
// - Floating strap leaves mode to software, default transparent.
// - Traffic indicator high while transmitting or receiving.
// - On a remote, link_up_n low while locked to hopping.
// - On a base, link_up_n low while a remote is connected.
//
// Local design decisions: the register addresses and the APB register port.
module rpl_pin_logic (
    input wire logic clk_in,                   // 200 MHz clock.
    input wire logic rst_in,                   // Synchronous reset, high.
    input wire logic psel_in,                  // APB select.
    input wire logic penable_in,               // APB enable.
    input wire logic pwrite_in,                // APB write.
    input wire logic [7:0] paddr_in,           // APB byte address.
    input wire logic [31:0] pwdata_in,         // APB write data.
    output logic [31:0] prdata_out,            // APB read data.
    output logic pready_out,                   // APB ready.
    output logic pslverr_out,                  // APB error, unmapped.
    input wire rpl_pkg::rpl_core_t core_in,    // Radio core status.
    input wire logic sleep_in,                 // Sleep pin, high sleeps.
    input wire logic cfg_n_in,                 // Mode strap, low protocol.
    input wire logic cfg_driven_in,            // Strap sensed as connected.
    input wire logic hop_align_in,             // Hop alignment pulse pin.
    input wire logic [5:0] general_io_in,      // GPIO pin levels.
    output logic [5:0] general_io_out,         // GPIO drive levels.
    output logic [5:0] general_io_oe_out,      // GPIO drive enables.
    output logic [5:0] general_io_pull_out,    // GPIO pull-up enables.
    output logic pulse_width_out_0,            // PWM output 0.
    output logic pulse_width_out_1,            // PWM output 1.
    output logic frame_marker,                 // Packet bracket marker.
    output logic traffic_indicator,            // Data activity.
    output logic link_up_n,                    // Carrier indicator, low.
    output logic protocol_mode_out,            // High in protocol mode.
    output logic sleep_out,                    // Module is asleep.
    output logic hop_align_out,                // Hop alignment pulse.
    output logic irq_out                       // Level interrupt.
);

    // ************************************************************
    // Synchronisers and wake reset
    // ************************************************************
    logic sleep_m_q, sleep_s_q, sleep_d_q;
    logic cfg_m_q, cfg_s_q;
    logic hop_m_q, hop_s_q, hop_d_q;
    logic sleep_q, por_q, wake_req, hop_rise, rst_all;

    // Asynchronous pins get two flops before any logic looks at them.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sleep_m_q <= 1'b0;
            sleep_s_q <= 1'b0;
            sleep_d_q <= 1'b0;
            cfg_m_q <= 1'b1;
            cfg_s_q <= 1'b1;
            hop_m_q <= 1'b0;
            hop_s_q <= 1'b0;
            hop_d_q <= 1'b0;
        end else begin
            sleep_m_q <= sleep_in;
            sleep_s_q <= sleep_m_q;
            sleep_d_q <= sleep_s_q;
            cfg_m_q <= cfg_n_in;
            cfg_s_q <= cfg_m_q;
            hop_m_q <= hop_align_in;
            hop_s_q <= hop_m_q;
            hop_d_q <= hop_s_q;
        end
    end

    // Edges are taken from the second and third flops only.
    assign hop_rise = hop_s_q && !hop_d_q;
    assign rst_all = rst_in || por_q;

    // Sleep starts on a rising sleep pin; the pin falling or a GPIO wake
    // ends it with a one-cycle power-on reset of the pin state.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sleep_q <= 1'b0;
            por_q <= 1'b0;
        end else begin
            por_q <= 1'b0;
            if (!sleep_q && sleep_s_q && !sleep_d_q) begin
                sleep_q <= 1'b1;
            end else if (sleep_q && (!sleep_s_q || wake_req)) begin
                sleep_q <= 1'b0;
                por_q <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [1:0] ctrl_q;
    logic [5:0] dir_q, out_q, pull_q, pon_q;
    logic [3:0] wake_q, slp_dir_q, slp_lvl_q, irq_en_q, irq_st_q;
    logic [2:0] alt_q;
    logic [7:0] duty0_q, duty1_q;
    logic [31:0] rd_d;
    logic hit, wr_en;

    // A write lands on the edge that completes the access phase.
    assign wr_en = psel_in && penable_in && pready_out && pwrite_in && hit;

    // Software settings survive the wake reset, like stored settings do.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_q <= rpl_pkg::CTRL_RST;
            dir_q <= rpl_pkg::GPIO_RST;
            pull_q <= rpl_pkg::GPIO_RST;
            pon_q <= rpl_pkg::PON_RST;
            wake_q <= rpl_pkg::SLP_RST;
            slp_dir_q <= rpl_pkg::SLP_RST;
            slp_lvl_q <= rpl_pkg::SLP_RST;
            alt_q <= rpl_pkg::ALT_RST;
            duty0_q <= rpl_pkg::PWM_RST;
            duty1_q <= rpl_pkg::PWM_RST;
            irq_en_q <= rpl_pkg::IRQ_RST;
        end else if (wr_en) begin
            unique case (paddr_in)
                rpl_pkg::OFS_CTRL: ctrl_q <= pwdata_in[1:0];
                rpl_pkg::OFS_DIR: dir_q <= pwdata_in[5:0];
                rpl_pkg::OFS_PULL: pull_q <= pwdata_in[5:0];
                rpl_pkg::OFS_PON: pon_q <= pwdata_in[5:0];
                rpl_pkg::OFS_WAKE: wake_q <= pwdata_in[3:0];
                rpl_pkg::OFS_SLP_DIR: slp_dir_q <= pwdata_in[3:0];
                rpl_pkg::OFS_SLP_LVL: slp_lvl_q <= pwdata_in[3:0];
                rpl_pkg::OFS_ALT: alt_q <= pwdata_in[2:0];
                rpl_pkg::OFS_PULSE_WIDTH_OUT_0: duty0_q <= pwdata_in[7:0];
                rpl_pkg::OFS_PULSE_WIDTH_OUT_1: duty1_q <= pwdata_in[7:0];
                rpl_pkg::OFS_IRQ_EN: irq_en_q <= pwdata_in[3:0];
                default: ;
            endcase
        end
    end

    // Output levels restart from the power-on levels after a wake reset.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out_q <= rpl_pkg::PON_RST;
        end else if (por_q) begin
            out_q <= pon_q;
        end else if (wr_en && paddr_in == rpl_pkg::OFS_OUT) begin
            out_q <= pwdata_in[5:0];
        end
    end

    // ************************************************************
    // APB read path and ready
    // ************************************************************
    // Decode for reads and writes; unmapped offsets answer with an error.
    always_comb begin
        rd_d = 32'h0000_0000;
        hit = 1'b1;
        unique case (paddr_in)
            rpl_pkg::OFS_CTRL: rd_d[1:0] = ctrl_q;
            rpl_pkg::OFS_DIR: rd_d[5:0] = dir_q;
            rpl_pkg::OFS_OUT: rd_d[5:0] = out_q;
            rpl_pkg::OFS_IN: rd_d[5:0] = general_io_in;
            rpl_pkg::OFS_PULL: rd_d[5:0] = pull_q;
            rpl_pkg::OFS_WAKE: rd_d[3:0] = wake_q;
            rpl_pkg::OFS_SLP_DIR: rd_d[3:0] = slp_dir_q;
            rpl_pkg::OFS_SLP_LVL: rd_d[3:0] = slp_lvl_q;
            rpl_pkg::OFS_PON: rd_d[5:0] = pon_q;
            rpl_pkg::OFS_ALT: rd_d[2:0] = alt_q;
            rpl_pkg::OFS_PULSE_WIDTH_OUT_0: rd_d[7:0] = duty0_q;
            rpl_pkg::OFS_PULSE_WIDTH_OUT_1: rd_d[7:0] = duty1_q;
            rpl_pkg::OFS_STAT: rd_d[4:0] = {sleep_out, protocol_mode_out,
                link_up_n, traffic_indicator, frame_marker};
            rpl_pkg::OFS_IRQ_ST: rd_d[3:0] = irq_st_q;
            rpl_pkg::OFS_IRQ_CLR: rd_d[3:0] = 4'h0;
            rpl_pkg::OFS_IRQ_EN: rd_d[3:0] = irq_en_q;
            default: hit = 1'b0;
        endcase
    end

    // One wait state keeps every bus output straight from a flop.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && penable_in && !pready_out) begin
            pready_out <= 1'b1;
            pslverr_out <= !hit;
            prdata_out <= pwrite_in ? 32'h0000_0000 : rd_d;
        end else begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic [3:0] ev, clr;

    assign ev = {wake_req && sleep_q, hop_rise, core_in.eop_done,
                 core_in.sop_done};
    assign clr = por_q ? ~4'(1 << rpl_pkg::IRQ_WAKE) :
                 (wr_en && paddr_in == rpl_pkg::OFS_IRQ_CLR) ? pwdata_in[3:0] : 4'h0;

    // A new event beats a clear; the wake cause outlives the wake reset.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_st_q <= rpl_pkg::IRQ_RST;
            irq_out <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~clr) | ev;
            irq_out <= |(((irq_st_q & ~clr) | ev) & irq_en_q);
        end
    end

    // ************************************************************
    // Indicators and mode
    // ************************************************************
    // Start wins over end so that a back-to-back packet keeps the marker.
    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            frame_marker <= 1'b0;
        end else if (core_in.sop_done) begin
            frame_marker <= 1'b1;
        end else if (core_in.eop_done) begin
            frame_marker <= 1'b0;
        end
    end

    // Indicators follow the core one cycle late.
    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            traffic_indicator <= 1'b0;
            link_up_n <= 1'b1;
            hop_align_out <= 1'b0;
            sleep_out <= 1'b0;
        end else begin
            traffic_indicator <= core_in.tx_busy || core_in.rx_busy;
            link_up_n <= ctrl_q[rpl_pkg::CTRL_BASE] ?
                         !core_in.remote_up :
                         !core_in.hop_locked;
            hop_align_out <= hop_rise;
            sleep_out <= sleep_q;
        end
    end

    // A floating strap cannot be sensed by the flops, so the pad sensing
    // line decides whether the strap or software picks the mode.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            protocol_mode_out <= 1'b0;
        end else if (cfg_driven_in) begin
            protocol_mode_out <= !cfg_s_q;
        end else begin
            protocol_mode_out <= ctrl_q[rpl_pkg::CTRL_PROTO];
        end
    end

    // ************************************************************
    // General I/O
    // ************************************************************
    logic [5:0] alt_on, alt_src, wake_hit;

    assign alt_on = {alt_q, 3'b000};
    assign alt_src = {core_in.ant_sel, core_in.serial_rx_pending,
                      core_in.rs485_de, 3'b000};
    // Wake sources are low levels on input ports with wake enabled.
    assign wake_hit = {2'b00, wake_q & ~dir_q[3:0] & ~general_io_in[3:0]};
    assign wake_req = |wake_hit;

    for (genvar i = 0; i < rpl_pkg::GPIO_N; i++) begin : g_io
        localparam bit SLP_CTL = (i < rpl_pkg::WAKE_N);
        logic oe_d, o_d;

        // Alternate function first, then sleep settings, then normal use.
        always_comb begin
            oe_d = dir_q[i];
            o_d = out_q[i];
            if (alt_on[i]) begin
                oe_d = 1'b1;
                o_d = alt_src[i];
            end else if (SLP_CTL && sleep_q) begin
                oe_d = slp_dir_q[i % rpl_pkg::WAKE_N];
                o_d = slp_lvl_q[i % rpl_pkg::WAKE_N];
            end
        end

        // Pull-ups only act while the port is an input.
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                general_io_oe_out[i] <= 1'b0;
                general_io_out[i] <= 1'b0;
                general_io_pull_out[i] <= 1'b0;
            end else begin
                general_io_oe_out[i] <= oe_d;
                general_io_out[i] <= o_d;
                general_io_pull_out[i] <= pull_q[i] && !oe_d;
            end
        end
    end

    // ************************************************************
    // PWM
    // ************************************************************
    logic [3:0] step_q;
    logic [7:0] pwm_cnt_q;

    // 256 steps of 15 cycles give a period just under 20 us.
    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            step_q <= 4'h0;
            pwm_cnt_q <= 8'h00;
        end else if (step_q == rpl_pkg::PWM_STEP_LAST) begin
            step_q <= 4'h0;
            pwm_cnt_q <= pwm_cnt_q + 8'h01;
        end else begin
            step_q <= step_q + 4'h1;
        end
    end

    // Duty 0 is always low; duty FF is high for 255 of 256 steps.
    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            pulse_width_out_0 <= 1'b0;
            pulse_width_out_1 <= 1'b0;
        end else begin
            pulse_width_out_0 <= pwm_cnt_q < duty0_q;
            pulse_width_out_1 <= pwm_cnt_q < duty1_q;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in || por_q);

    sequence s_hop_rise;
        !hop_s_q ##1 hop_s_q;
    endsequence

    sequence s_wake;
        sleep_q && !sleep_s_q;
    endsequence

    chk_frame_set: assert property (core_in.sop_done |=> frame_marker)
        else $error("frame marker did not rise");
    chk_frame_clr: assert property (
        core_in.eop_done && !core_in.sop_done |=> !frame_marker)
        else $error("frame marker did not fall");
    chk_traffic_lvl: assert property (
        !$past(por_q) |-> traffic_indicator == $past(core_in.tx_busy || core_in.rx_busy))
        else $error("traffic indicator wrong");
    chk_link_remote: assert property (
        !ctrl_q[rpl_pkg::CTRL_BASE] && core_in.hop_locked && $stable(ctrl_q)
        |=> !link_up_n)
        else $error("remote carrier indicator wrong");
    chk_link_base: assert property (
        ctrl_q[rpl_pkg::CTRL_BASE] && $stable(ctrl_q)
        |=> link_up_n == !$past(core_in.remote_up))
        else $error("base carrier indicator wrong");
    chk_sleep_enter: assert property (
        !sleep_q && sleep_s_q && !sleep_d_q |=> ##1 sleep_out)
        else $error("sleep not entered");
    chk_wake_reset: assert property (disable iff (rst_in) s_wake |=> por_q ##1 !sleep_out)
        else $error("no power-on reset on wake");
    chk_hop_edge: assert property (s_hop_rise |=> hop_align_out)
        else $error("hop align edge missed");
    chk_mode_strap: assert property (
        cfg_driven_in |=> protocol_mode_out == !$past(cfg_s_q))
        else $error("strap mode wrong");
    chk_mode_soft: assert property (
        !cfg_driven_in |=> protocol_mode_out == $past(ctrl_q[0]))
        else $error("software mode wrong");
    chk_alt_de: assert property (
        alt_q[rpl_pkg::ALT_DE] |=> general_io_oe_out[3] &&
        general_io_out[3] == $past(core_in.rs485_de))
        else $error("driver enable not on port 3");
    chk_pwm_duty: assert property (
        duty0_q == 8'h00 && $stable(duty0_q) |=> !pulse_width_out_0)
        else $error("pwm high at zero duty");

endmodule

// ### testbench/rpl_host_model.sv
// Host-side model that drives the hop alignment pin with a pulse train.
// Assumes one clock shared with the design; go_in gates the pulses.
module rpl_host_model #(
    parameter int WIDTH_CYC = 20, // Pulse width, scaled down to keep runs short.
    parameter int SPACE_CYC = 80  // Pulse spacing, scaled down likewise.
) (
    input wire logic clk_in,   // Shared clock.
    input wire logic go_in,    // High while pulses are wanted.
    output logic hop_align_out // Alignment pin to the design.
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    // ************************************************************
    // Pulse train
    // ************************************************************
    // The counter is two-state, so the pin is defined from time zero.
    always_ff @(posedge clk_in) begin
        if (!go_in) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= (cnt_q == SPACE_CYC - 1) ? 0 : cnt_q + 1;
        end
    end
    // Fixed width keeps every pulse inside the host's limits.
    assign hop_align_out = go_in & (cnt_q < WIDTH_CYC);
endmodule

// ### testbench/tb.sv
// Self-checking bench for the host pin logic, driven over APB.
// Assumes rpl_pkg, rpl_pin_logic and the host model are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SPACE = 80;
    logic clk_in, rst_in, psel, penable, pwrite, sleep_in, cfg_n, cfg_drv, go, er;
    logic pready, pslverr, hop_pin, hop_out, fm, act, link_n, proto, slp, irq, pw0, pw1;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] gin, gout, goe, gpull;
    rpl_pkg::rpl_core_t core;
    int errors, compares, n, m;
    rpl_pin_logic rpl_pin_logic_inst (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .core_in(core),
        .sleep_in(sleep_in), .cfg_n_in(cfg_n), .cfg_driven_in(cfg_drv),
        .hop_align_in(hop_pin), .general_io_in(gin), .general_io_out(gout),
        .general_io_oe_out(goe), .general_io_pull_out(gpull), .pulse_width_out_0(pw0),
        .pulse_width_out_1(pw1), .frame_marker(fm), .traffic_indicator(act),
        .link_up_n(link_n), .protocol_mode_out(proto), .sleep_out(slp),
        .hop_align_out(hop_out), .irq_out(irq));
    rpl_host_model #(.SPACE_CYC(SPACE)) rpl_host_model_inst (.clk_in(clk_in),
        .go_in(go), .hop_align_out(hop_pin));
    // ************************************************************
    // Clock, tasks and watchdog
    // ************************************************************
    // The 5 ns clock.
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic end_sim();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk_in);
    endtask
    // One transfer; the request stands until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1) begin
            @(posedge clk_in);
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // One-cycle start (s high) or end (s low) event from the radio core.
    task automatic ev(input logic s);
        @(posedge clk_in);
        {core.sop_done, core.eop_done} <= {s, !s};
        @(posedge clk_in);
        {core.sop_done, core.eop_done} <= 2'b00;
        wt(2);
    endtask
    // A hang is cut short well beyond the expected run of about 8100 cycles.
    initial begin
        wt(30000);
        errors++;
        end_sim();
    end
    // ************************************************************
    // Test sequence
    // ************************************************************
    // Each step drives at a rising edge and checks once outputs settle.
    initial begin
        errors = 0;
        compares = 0;
        {psel, penable, pwrite, sleep_in, cfg_drv, go, cfg_n, rst_in} = 8'h03;
        {paddr, pwdata, core, gin} = '1;
        core = '0;
        wt(5);
        rst_in <= 1'b0;
        chk({link_n, irq, fm, act, slp}, 5'h10);
        for (int i = 0; i < 16; i++) begin
            rchk(8'(4 * i), i == 3 ? 32'h3F : i == 12 ? 32'h4 : 32'h0);
        end
        rchk(8'h40, 32'h0);
        chk(er, 1'b1);
        wr(rpl_pkg::OFS_IRQ_EN, 32'h3);
        ev(1'b1);
        chk({fm, irq}, 2'b11);
        ev(1'b0);
        chk(fm, 1'b0);
        rchk(rpl_pkg::OFS_IRQ_ST, 32'h3);
        wr(rpl_pkg::OFS_IRQ_CLR, 32'h3);
        wr(rpl_pkg::OFS_IRQ_EN, 32'h0);
        ev(1'b1);
        chk({fm, irq}, 2'b10);
        for (int i = 1; i < 5; i++) begin
            {core.tx_busy, core.rx_busy} <= 2'(i);
            wt(3);
            chk(act, i < 4);
        end
        core.hop_locked <= 1'b1;
        wt(3);
        chk(link_n, 1'b0);
        wr(rpl_pkg::OFS_CTRL, 32'h2);
        wt(2);
        chk(link_n, 1'b1);
        core.remote_up <= 1'b1;
        wt(3);
        chk(link_n, 1'b0);
        {cfg_drv, cfg_n} <= 2'b10;
        wt(6);
        chk(proto, 1'b1);
        cfg_n <= 1'b1;
        wt(6);
        chk(proto, 1'b0);
        cfg_drv <= 1'b0;
        wr(rpl_pkg::OFS_CTRL, 32'h1);
        wt(6);
        chk(proto, 1'b1);
        wr(rpl_pkg::OFS_IRQ_EN, 32'h4);
        go <= 1'b1;
        n = 0;
        repeat (2 * SPACE) begin
            @(posedge clk_in);
            n += int'(hop_out === 1'b1);
        end
        go <= 1'b0;
        chk(32'(n), 32'd2);
        chk(irq, 1'b1);
        wr(rpl_pkg::OFS_PULSE_WIDTH_OUT_0, 32'h80);
        wr(rpl_pkg::OFS_PULSE_WIDTH_OUT_1, 32'h01);
        wt(rpl_pkg::PWM_STEP_CYC * 256);
        {n, m} = '0;
        repeat (rpl_pkg::PWM_STEP_CYC * 256) begin
            @(posedge clk_in);
            n += int'(pw0 === 1'b1);
            m += int'(pw1 === 1'b1);
        end
        chk(32'(n), 32'(128 * rpl_pkg::PWM_STEP_CYC));
        chk(32'(m), 32'(rpl_pkg::PWM_STEP_CYC));
        wr(rpl_pkg::OFS_DIR, 32'h1);
        wr(rpl_pkg::OFS_OUT, 32'h1);
        wr(rpl_pkg::OFS_PULL, 32'h32);
        wt(2);
        chk({goe[1:0], gout[0], gpull}, 9'h0F2);
        {core.rs485_de, core.serial_rx_pending, core.ant_sel} <= 3'b111;
        for (int i = 0; i < 3; i++) begin
            wr(rpl_pkg::OFS_ALT, 32'(1 << i));
            wt(2);
            chk({goe[3 + i], gout[3 + i]}, 2'b11);
        end
        wr(rpl_pkg::OFS_ALT, 32'h0);
        wr(rpl_pkg::OFS_SLP_DIR, 32'h2);
        wr(rpl_pkg::OFS_SLP_LVL, 32'h2);
        wr(rpl_pkg::OFS_PON, 32'h4);
        sleep_in <= 1'b1;
        wt(8);
        chk({slp, goe[1], gout[1]}, 3'b111);
        sleep_in <= 1'b0;
        wt(8);
        chk({slp, fm, gout[2:0]}, 5'h04);
        wr(rpl_pkg::OFS_WAKE, 32'h1);
        wr(rpl_pkg::OFS_DIR, 32'h0);
        sleep_in <= 1'b1;
        wt(8);
        gin[0] <= 1'b0;
        n = 0;
        while (slp !== 1'b0 && n < 20) begin
            @(posedge clk_in);
            n++;
        end
        chk(32'(n < 20), 32'h1);
        rchk(rpl_pkg::OFS_IRQ_ST, 32'h8);
        end_sim();
    end
endmodule
